// ===== src/aleb_pkg.sv
package aleb_pkg;

	// field widths of the instruction word
	localparam int unsigned WORD_W = 32;
	localparam int unsigned OPC_W = 6;
	localparam int unsigned REG_W = 5;
	localparam int unsigned TAIL_W = 11;
	localparam int unsigned IMM_W = 16;

	// instruction word, bit 0 of the encoding is the msb here
	typedef struct packed {
		logic [OPC_W-1:0] opcode;
		logic [REG_W-1:0] dst;
		logic [REG_W-1:0] src_a;
		logic [REG_W-1:0] src_b;
		logic [TAIL_W-1:0] tail;
	} aleb_instr_t;

	// positions inside the opcode field
	localparam int unsigned OPC_TYPEB_BIT = 3;
	localparam int unsigned OPC_KEEP_BIT = 2;
	localparam int unsigned OPC_CIN_BIT = 1;
	localparam int unsigned OPC_LSB_BIT = 0;
	localparam logic [1:0] OPC_ADD_TOP = 2'h0;
	localparam logic OPC_ADD_LSB = 1'h0;
	localparam logic [OPC_W-1:0] OPC_AND = 6'h21;
	localparam logic [OPC_W-1:0] OPC_ANDI = 6'h29;
	localparam logic [OPC_W-1:0] OPC_ANDN = 6'h23;
	localparam logic [OPC_W-1:0] OPC_ANDNI = 6'h2b;
	localparam logic [OPC_W-1:0] OPC_BEQ = 6'h27;
	localparam logic [OPC_W-1:0] OPC_BEQI = 6'h2f;

	// branch condition lives in the destination field
	localparam int unsigned BR_DELAY_BIT = 4;
	localparam logic [REG_W-2:0] BR_COND_EQ = 4'h0;

	localparam logic [TAIL_W-1:0] TAIL_ZERO = 11'h000;
	localparam logic [WORD_W-1:0] WORD_ZERO = 32'h00000000;
	localparam logic [WORD_W-1:0] PC_STEP = 32'h00000004;
	localparam logic [WORD_W-1:0] RESET_PC_DEFAULT = 32'h00000000;

	// operation selected by decode
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_AND,
		OP_ANDN,
		OP_BEQ,
		OP_TRAP
	} aleb_op_t;

	// registered result of the execute stage
	typedef struct packed {
		logic valid;
		logic [REG_W-1:0] addr;
		logic [WORD_W-1:0] data;
	} aleb_wb_t;

endpackage : aleb_pkg

// ===== src/aleb_regfile.sv
`timescale 1ns/1ns
module aleb_regfile #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = 32,
	parameter int unsigned AW = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// read side
	input wire logic i_rd_en,
	input wire logic [AW-1:0] i_rd_addr_a,
	input wire logic [AW-1:0] i_rd_addr_b,
	output logic [WIDTH-1:0] o_rd_data_a,
	output logic [WIDTH-1:0] o_rd_data_b,
	// write side
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data
);

	initial
	begin
		if (DEPTH < 2 || (1 << AW) < DEPTH || WIDTH < 1)
			$error("aleb_regfile: unsupported size");
	end

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_ref_clk)
	begin
		if (i_wr_en)
			mem[i_wr_addr] <= i_wr_data;
	end

	// write-first so a result is seen by the very next instruction
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_rd_data_a <= '0;
			o_rd_data_b <= '0;
		end
		else if (i_rd_en)
		begin
			o_rd_data_a <= (i_wr_en && i_wr_addr == i_rd_addr_a) ? i_wr_data : mem[i_rd_addr_a];
			o_rd_data_b <= (i_wr_en && i_wr_addr == i_rd_addr_b) ? i_wr_data : mem[i_rd_addr_b];
		end
	end

endmodule : aleb_regfile

// ===== src/aleb_core.sv
`timescale 1ns/1ns
module aleb_core #(
	parameter logic [31:0] RESET_PC = aleb_pkg::RESET_PC_DEFAULT,
	parameter int unsigned ZERO_OPCODE_TRAP_PARAM = 0,
	parameter int unsigned RF_DEPTH = 32
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// instruction in
	input wire logic i_instr_valid,
	input wire logic [aleb_pkg::WORD_W-1:0] i_instr,
	output logic o_ready,
	// upper half from a preceding immediate prefix
	input wire logic i_imm_prefix_valid,
	input wire logic [aleb_pkg::IMM_W-1:0] i_imm_prefix_hi,
	// configuration
	input wire logic i_illegal_exc_en,
	// state
	output logic [aleb_pkg::WORD_W-1:0] o_program_counter,
	output logic o_status_carry_flag,
	// events
	output logic o_retire,
	output logic o_redirect,
	output logic [aleb_pkg::WORD_W-1:0] o_redirect_target,
	output logic o_illegal_trap,
	output logic o_wb_valid,
	output logic [aleb_pkg::REG_W-1:0] o_wb_addr,
	output logic [aleb_pkg::WORD_W-1:0] o_wb_data
);

	initial
	begin
		if (ZERO_OPCODE_TRAP_PARAM > 1)
			$error("aleb_core: trap parameter must be 0 or 1");
		if (RF_DEPTH != (1 << aleb_pkg::REG_W))
			$error("aleb_core: register file depth must match register field");
	end

	typedef enum logic [1:0] {
		ST_RUN,
		ST_BUBBLE,
		ST_SLOT
	} aleb_state_t;

	aleb_state_t state;
	aleb_state_t next_state;

	// execute stage holding
	logic exec_valid;
	aleb_pkg::aleb_instr_t exec_instr;
	logic exec_prefix_valid;
	logic [aleb_pkg::IMM_W-1:0] exec_prefix_hi;
	logic [aleb_pkg::WORD_W-1:0] slot_target;

	logic accept;
	logic [aleb_pkg::WORD_W-1:0] rd_a;
	logic [aleb_pkg::WORD_W-1:0] rd_b;

	// decode and execute
	aleb_pkg::aleb_op_t op;
	logic type_b;
	logic keep_carry;
	logic carry_in_sel;
	logic delay_slot;
	logic [aleb_pkg::WORD_W-1:0] imm_ext;
	logic [aleb_pkg::WORD_W-1:0] operand_b;
	logic [aleb_pkg::WORD_W:0] sum;
	logic [aleb_pkg::WORD_W-1:0] result;
	logic write_en;
	logic taken;
	logic [aleb_pkg::WORD_W-1:0] target;
	aleb_pkg::aleb_wb_t wb;

	assign accept = i_instr_valid && o_ready;

	aleb_regfile #(
		.WIDTH(aleb_pkg::WORD_W),
		.DEPTH(RF_DEPTH),
		.AW(aleb_pkg::REG_W)
	) u_regfile (
		.i_ref_clk(i_ref_clk),
		.i_arst_n(i_arst_n),
		.i_rd_en(accept),
		.i_rd_addr_a(i_instr[aleb_pkg::WORD_W-aleb_pkg::OPC_W-aleb_pkg::REG_W-1 -: aleb_pkg::REG_W]),
		.i_rd_addr_b(i_instr[aleb_pkg::TAIL_W +: aleb_pkg::REG_W]),
		.o_rd_data_a(rd_a),
		.o_rd_data_b(rd_b),
		.i_wr_en(write_en),
		.i_wr_addr(exec_instr.dst),
		.i_wr_data(result)
	);

	// capture of the instruction and its prefix
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			exec_valid <= 1'b0;
			exec_instr <= '0;
			exec_prefix_valid <= 1'b0;
			exec_prefix_hi <= '0;
		end
		else
		begin
			exec_valid <= accept;
			if (accept)
			begin
				exec_instr <= aleb_pkg::aleb_instr_t'(i_instr);
				exec_prefix_valid <= i_imm_prefix_valid;
				exec_prefix_hi <= i_imm_prefix_hi;
			end
		end
	end

	// decode
	always_comb
	begin
		op = aleb_pkg::OP_NONE;
		type_b = exec_instr.opcode[aleb_pkg::OPC_TYPEB_BIT];
		keep_carry = exec_instr.opcode[aleb_pkg::OPC_KEEP_BIT];
		carry_in_sel = exec_instr.opcode[aleb_pkg::OPC_CIN_BIT];
		delay_slot = exec_instr.dst[aleb_pkg::BR_DELAY_BIT];
		if (ZERO_OPCODE_TRAP_PARAM == 1 && i_illegal_exc_en && exec_instr == aleb_pkg::WORD_ZERO)
			op = aleb_pkg::OP_TRAP;
		else if (exec_instr.opcode[aleb_pkg::OPC_W-1 -: 2] == aleb_pkg::OPC_ADD_TOP
			&& exec_instr.opcode[aleb_pkg::OPC_LSB_BIT] == aleb_pkg::OPC_ADD_LSB)
		begin
			if (type_b || exec_instr.tail == aleb_pkg::TAIL_ZERO)
				op = aleb_pkg::OP_ADD;
		end
		else if (exec_instr.opcode == aleb_pkg::OPC_AND && exec_instr.tail == aleb_pkg::TAIL_ZERO)
			op = aleb_pkg::OP_AND;
		else if (exec_instr.opcode == aleb_pkg::OPC_ANDI)
			op = aleb_pkg::OP_AND;
		else if (exec_instr.opcode == aleb_pkg::OPC_ANDN && exec_instr.tail == aleb_pkg::TAIL_ZERO)
			op = aleb_pkg::OP_ANDN;
		else if (exec_instr.opcode == aleb_pkg::OPC_ANDNI)
			op = aleb_pkg::OP_ANDN;
		else if (exec_instr.opcode == aleb_pkg::OPC_BEQ && exec_instr.tail == aleb_pkg::TAIL_ZERO
			&& exec_instr.dst[aleb_pkg::REG_W-2:0] == aleb_pkg::BR_COND_EQ)
			op = aleb_pkg::OP_BEQ;
		else if (exec_instr.opcode == aleb_pkg::OPC_BEQI
			&& exec_instr.dst[aleb_pkg::REG_W-2:0] == aleb_pkg::BR_COND_EQ)
			op = aleb_pkg::OP_BEQ;
		if (!exec_valid)
			op = aleb_pkg::OP_NONE;
	end

	// operand b: register or extended immediate
	always_comb
	begin
		if (exec_prefix_valid)
			imm_ext = {exec_prefix_hi, exec_instr.src_b, exec_instr.tail};
		else
			imm_ext = {{(aleb_pkg::WORD_W-aleb_pkg::IMM_W){exec_instr.src_b[aleb_pkg::REG_W-1]}},
				exec_instr.src_b, exec_instr.tail};
		operand_b = type_b ? imm_ext : rd_b;
	end

	// 33-bit sum keeps the unsigned carry out of the msb
	always_comb
	begin
		sum = {1'b0, rd_a} + {1'b0, operand_b}
			+ {{aleb_pkg::WORD_W{1'b0}}, carry_in_sel & o_status_carry_flag};
	end

	// result and writeback
	always_comb
	begin
		result = '0;
		write_en = 1'b0;
		case (op)
			aleb_pkg::OP_ADD:
			begin
				result = sum[aleb_pkg::WORD_W-1:0];
				write_en = 1'b1;
			end
			aleb_pkg::OP_AND:
			begin
				result = rd_a & operand_b;
				write_en = 1'b1;
			end
			aleb_pkg::OP_ANDN:
			begin
				result = rd_a & ~operand_b;
				write_en = 1'b1;
			end
			default:
			begin
				result = '0;
				write_en = 1'b0;
			end
		endcase
	end

	// branch decision
	always_comb
	begin
		taken = (op == aleb_pkg::OP_BEQ) && (rd_a == aleb_pkg::WORD_ZERO);
		target = o_program_counter + operand_b;
	end

	// issue control: stall cycles after a taken branch
	always_comb
	begin
		next_state = state;
		o_ready = 1'b1;
		case (state)
			ST_RUN:
			begin
				if (taken)
				begin
					o_ready = 1'b0;
					next_state = delay_slot ? ST_SLOT : ST_BUBBLE;
				end
			end
			ST_BUBBLE:
			begin
				o_ready = 1'b0;
				next_state = ST_RUN;
			end
			ST_SLOT:
			begin
				if (exec_valid)
					next_state = ST_RUN;
			end
			default:
			begin
				next_state = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	// program counter
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_program_counter <= RESET_PC;
		else if (exec_valid)
		begin
			if (state == ST_SLOT)
				o_program_counter <= slot_target;
			else if (taken && !delay_slot)
				o_program_counter <= target;
			else
				o_program_counter <= o_program_counter + aleb_pkg::PC_STEP;
		end
	end

	// target parked while the delay slot runs
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			slot_target <= '0;
		else if (taken && delay_slot)
			slot_target <= target;
	end

	// carry flag
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_status_carry_flag <= 1'b0;
		else if (op == aleb_pkg::OP_ADD && !keep_carry)
			o_status_carry_flag <= sum[aleb_pkg::WORD_W];
	end

	// retire and trap pulses
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_retire <= 1'b0;
			o_illegal_trap <= 1'b0;
		end
		else
		begin
			o_retire <= exec_valid && op != aleb_pkg::OP_TRAP;
			o_illegal_trap <= op == aleb_pkg::OP_TRAP;
		end
	end

	// taken-branch report
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_redirect <= 1'b0;
			o_redirect_target <= '0;
		end
		else
		begin
			o_redirect <= taken;
			if (taken)
				o_redirect_target <= target;
		end
	end

	// writeback copy kept as one record
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			wb <= '0;
		else
		begin
			wb.valid <= write_en;
			if (write_en)
			begin
				wb.addr <= exec_instr.dst;
				wb.data <= result;
			end
		end
	end

	assign o_wb_valid = wb.valid;
	assign o_wb_addr = wb.addr;
	assign o_wb_data = wb.data;

endmodule : aleb_core

// ===== bench/aleb_core_properties.sv
`timescale 1ns/1ns
module aleb_core_properties (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	// watched ports
	input wire logic i_instr_valid,
	input wire logic [31:0] i_instr,
	input wire logic o_ready,
	input wire logic i_illegal_exc_en,
	input wire logic [31:0] o_program_counter,
	input wire logic o_status_carry_flag,
	input wire logic o_retire,
	input wire logic o_redirect,
	input wire logic [31:0] o_redirect_target,
	input wire logic o_illegal_trap,
	input wire logic o_wb_valid
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_arst_n);
	property p_wb_lat;
		(o_wb_valid || o_retire) |-> $past(i_instr_valid && o_ready, 2);
	endproperty
	a_wb_lat: assert property (p_wb_lat) else $error("result without accept");
	property p_trap_quiet;
		o_illegal_trap |-> !o_wb_valid && !o_retire;
	endproperty
	a_trap_quiet: assert property (p_trap_quiet) else $error("trap wrote");
	property p_trap_cause;
		o_illegal_trap |-> $past(i_instr, 2) == 32'h00000000 && $past(i_illegal_exc_en);
	endproperty
	a_trap_cause: assert property (p_trap_cause) else $error("trap cause");
	property p_keep;
		$past(i_instr_valid && o_ready && i_instr[31:30] == 2'h0 && i_instr[28], 2) |-> $stable(o_status_carry_flag);
	endproperty
	a_keep: assert property (p_keep) else $error("kept carry moved");
	property p_logic_keep;
		$past(i_instr_valid && o_ready && i_instr[31], 2) |-> $stable(o_status_carry_flag);
	endproperty
	a_logic_keep: assert property (p_logic_keep) else $error("logic op moved carry");
	property p_nodelay;
		o_redirect && !$past(i_instr[25], 2) |-> !o_ready ##1 o_ready;
	endproperty
	a_nodelay: assert property (p_nodelay) else $error("stall length");
	property p_delay;
		o_redirect && $past(i_instr[25], 2) |-> o_ready && !$past(o_ready);
	endproperty
	a_delay: assert property (p_delay) else $error("delay slot stall");
	property p_pc_step;
		o_retire && !o_redirect && !$past(o_redirect, 2) |-> o_program_counter == $past(o_program_counter) + 32'h4;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc step");
	property p_redir_pc;
		o_redirect && !$past(i_instr[25], 2) |-> o_program_counter == o_redirect_target;
	endproperty
	a_redir_pc: assert property (p_redir_pc) else $error("pc not target");
	c_delay: cover property (o_redirect && $past(i_instr[25], 2));
	c_nodelay: cover property (o_redirect && !$past(i_instr[25], 2));
	c_trap: cover property (o_illegal_trap);
endmodule : aleb_core_properties
bind aleb_core aleb_core_properties u_props (.i_ref_clk, .i_arst_n, .i_instr_valid, .i_instr, .o_ready,
	.i_illegal_exc_en, .o_program_counter, .o_status_carry_flag, .o_retire, .o_redirect,
	.o_redirect_target, .o_illegal_trap, .o_wb_valid);

// ===== bench/aleb_core_tb.sv
`timescale 1ns/1ns
module aleb_core_tb;
	logic i_ref_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_instr_valid = 1'b0;
	logic [31:0] i_instr = 32'h0;
	logic i_imm_prefix_valid = 1'b0;
	logic [15:0] i_imm_prefix_hi = 16'h0;
	logic i_illegal_exc_en = 1'b0;
	logic o_ready, o_status_carry_flag, o_retire, o_redirect, o_illegal_trap, o_wb_valid;
	logic [31:0] o_program_counter, o_redirect_target, o_wb_data;
	logic [4:0] o_wb_addr;
	logic [15:0] ph = 16'h0;
	logic pv = 1'b0;
	logic [31:0] npc = 32'h0;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	int acc = 0;
	aleb_core #(.ZERO_OPCODE_TRAP_PARAM(1)) uut (.i_ref_clk, .i_arst_n, .i_instr_valid, .i_instr, .o_ready,
		.i_imm_prefix_valid, .i_imm_prefix_hi, .i_illegal_exc_en, .o_program_counter, .o_status_carry_flag,
		.o_retire, .o_redirect, .o_redirect_target, .o_illegal_trap, .o_wb_valid, .o_wb_addr, .o_wb_data);
	initial forever #5 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (cyc > 2000)
		begin
			mismatches++;
			finish_test();
		end
	end
	task finish_test;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [31:0] ia(input logic [5:0] o, input logic [4:0] d, a, b);
		return {o, d, a, b, 11'h000};
	endfunction : ia
	function automatic logic [31:0] ib(input logic [5:0] o, input logic [4:0] d, a, input logic [15:0] m);
		return {o, d, a, m};
	endfunction : ib
	// offer one word, return just after the accepting edge
	task issue(input logic [31:0] ins);
		int w;
		@(negedge i_ref_clk);
		i_instr_valid = 1'b1;
		i_instr = ins;
		i_imm_prefix_valid = pv;
		i_imm_prefix_hi = ph;
		w = 0;
		while (o_ready !== 1'b1 && w < 20)
		begin
			@(negedge i_ref_clk);
			w++;
		end
		@(posedge i_ref_clk);
		#1;
		acc = cyc;
		npc = npc + 32'h4;
	endtask : issue
	task idle(input int n);
		@(negedge i_ref_clk);
		i_instr_valid = 1'b0;
		i_imm_prefix_valid = 1'b0;
		repeat (n) @(negedge i_ref_clk);
	endtask : idle
	task run(input logic [31:0] ins, input logic [31:0] ed, input logic ec);
		issue(ins);
		idle(1);
		chk("wb_valid", o_wb_valid, 1);
		chk("wb_addr", o_wb_addr, ins[25:21]);
		chk("retire", o_retire, 1);
		chk("wb_data", o_wb_data, ed);
		chk("carry", o_status_carry_flag, ec);
	endtask : run
	task ld(input logic [4:0] d, input logic [31:0] v);
		pv = 1'b1;
		ph = v[31:16];
		run(ib(6'h0c, d, 5'h0, v[15:0]), v, 1'b0);
		pv = 1'b0;
	endtask : ld
	task t_load;
		run(ib(aleb_pkg::OPC_ANDI, 0, 0, 16'h0), 0, 0);
		ld(1, 32'hffffffff);
		ld(2, 32'h1);
		ld(3, 32'h80000000);
		ld(8, 32'h8040);
	endtask : t_load
	task t_add;
		run(ia(6'h00, 4, 1, 2), 32'h0, 1);
		run(ia(6'h04, 5, 2, 2), 32'h2, 1);
		run(ia(6'h06, 5, 2, 2), 32'h3, 1);
		run(ia(6'h02, 6, 2, 2), 32'h3, 0);
		run(ia(6'h04, 5, 3, 3), 32'h0, 0);
		run(ia(6'h02, 6, 2, 2), 32'h2, 0);
		run(ia(6'h00, 6, 1, 1), 32'hfffffffe, 1);
		run(ib(6'h08, 7, 2, 16'hfffe), 32'hffffffff, 0);
		run(ib(6'h0a, 7, 1, 16'h0001), 32'h0, 1);
		run(ib(6'h0e, 7, 2, 16'h8000), 32'hffff8002, 1);
	endtask : t_add
	task t_logic;
		run(ia(aleb_pkg::OPC_AND, 9, 1, 3), 32'h80000000, 1);
		run(ib(aleb_pkg::OPC_ANDI, 9, 1, 16'h8001), 32'hffff8001, 1);
		run(ia(aleb_pkg::OPC_ANDN, 9, 1, 3), 32'h7fffffff, 1);
		run(ib(aleb_pkg::OPC_ANDNI, 9, 1, 16'h8000), 32'h00007fff, 1);
		issue({aleb_pkg::OPC_AND, 5'h9, 5'h1, 5'h3, 11'h001});
		idle(1);
		chk("tail_wb", o_wb_valid, 0);
	endtask : t_logic
	task br(input logic [31:0] ins, input logic [31:0] off, input logic tk, d);
		logic [31:0] b;
		int t0;
		b = npc;
		issue(ins);
		t0 = acc;
		if (tk && !d)
			npc = b + off;
		issue(ia(aleb_pkg::OPC_AND, 9, 2, 2));
		chk("spacing", acc - t0, tk ? (d ? 2 : 3) : 1);
		if (tk && d)
			npc = b + off;
		idle(3);
		if (tk)
			chk("target", o_redirect_target, b + off);
		chk("pc", o_program_counter, npc);
	endtask : br
	task t_branch;
		br(ia(aleb_pkg::OPC_BEQ, 5'h00, 0, 8), 32'h8040, 1, 0);
		br(ia(aleb_pkg::OPC_BEQ, 5'h10, 0, 8), 32'h8040, 1, 1);
		br(ia(aleb_pkg::OPC_BEQ, 5'h00, 2, 8), 32'h0, 0, 0);
		br(ib(aleb_pkg::OPC_BEQI, 5'h00, 0, 16'hfff0), 32'hfffffff0, 1, 0);
		br(ib(aleb_pkg::OPC_BEQI, 5'h10, 0, 16'hfff0), 32'hfffffff0, 1, 1);
		br(ib(aleb_pkg::OPC_BEQI, 5'h10, 2, 16'hfff0), 32'h0, 0, 1);
	endtask : t_branch
	task t_trap;
		@(negedge i_ref_clk);
		i_illegal_exc_en = 1'b1;
		issue(32'h0);
		idle(1);
		chk("trap", o_illegal_trap, 1);
		chk("trap_wb", o_wb_valid, 0);
		chk("trap_retire", o_retire, 0);
		i_illegal_exc_en = 1'b0;
		run(32'h0, 32'h0, 0);
		chk("no_trap", o_illegal_trap, 0);
	endtask : t_trap
	initial
	begin
		repeat (20) @(negedge i_ref_clk);
		i_arst_n = 1'b1;
		t_load();
		t_add();
		t_logic();
		t_branch();
		t_trap();
		finish_test();
	end
endmodule : aleb_core_tb
